// >>> e1_status_regs.sv
// status, receive information and synchronizer registers of four framers
//
// Summary of operation
// - event bits latch high and stay until host clears them with a mask write; sync register excluded
// - after clearing, bit sets again on new event or while condition persists
// - mask bit one loads read value with current state and clears latch
// - mask bit zero holds read value and leaves latched event alone
// - synchronizer register is live, read only, needs no mask write
// - only the two alarm status registers drive the shared interrupt
// - each alarm status bit gated by matching interrupt mask bit
// - summary bit 2n is framer n status a, bit 2n+1 status b
// - transmit store full sets bit 7, empty sets bit 6
// - receive store full sets bit 4, empty sets bit 3
// - receive clock quiet about three microseconds sets bit 5
// - 915 errored CRC words of 1000 sets bit 2
// - three consecutive errored frame alignment words set bit 1
// - two consecutive errored multiframe alignment words set bit 0
// - sync register bits 2,1,0 show FAS, CAS, CRC4 searching
// - sync counter adds one on each 8 ms CRC4 search timeout
// - sync counter clears on CRC4 sync or when CRC4 mode off
// - sync counter wraps to zero past its maximum
`timescale 1ns/100ps
`include "e1s_consts.svh"
module e1_status_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire e1s_pkg::host_req_t host_req,
  output logic [7:0] host_rdata,
  input wire e1s_pkg::framer_ev_t framer_ev [4],
  input wire logic [3:0] rclk_pin,
  input wire logic [3:0] crc_mode_enable,
  output logic int_n
);

  localparam int QUIET_CYC = `E1S_RCLK_QUIET_CYC;
  localparam logic [6:0] QUIET_LIMIT = 7'(QUIET_CYC);

  // per-framer views, each element driven by one framer slice
  logic [7:0] lat_a [4];
  logic [7:0] lat_b [4];
  logic [7:0] lat_info [4];
  logic [7:0] rd_a [4];
  logic [7:0] rd_b [4];
  logic [7:0] rd_info [4];
  logic [7:0] imr_a_r [4];
  logic [7:0] imr_b_r [4];
  logic [7:0] sync_view [4];
  logic [7:0] summ_nxt;
  logic [7:0] summ_r;
  logic int_n_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // host access decode, shared by all framers
  wire host_wr = host_req.cs & host_req.wr;
  wire host_rd = host_req.cs & host_req.rd;
  wire [1:0] sel_f = host_req.fs;

  genvar f;
  generate
    for (f = 0; f < 4; f++) begin : g_fr
      logic rclk_s1_r;
      logic rclk_s2_r;
      logic rclk_s3_r;
      logic [6:0] quiet_r;
      logic [6:0] quiet_nxt;
      logic [9:0] word_cnt_r;
      logic [9:0] err_cnt_r;
      logic crc_hit_r;
      logic [1:0] fas_run_r;
      logic fas_hit_r;
      logic [1:0] cas_run_r;
      logic cas_hit_r;
      logic [5:0] sync_cnt_r;
      logic [5:0] sync_cnt_nxt;

      wire fsel = host_wr & (sel_f == 2'(f));
      wire wr_a = fsel & (host_req.addr == `E1S_OFS_STATUS_A);
      wire wr_b = fsel & (host_req.addr == `E1S_OFS_STATUS_B);
      wire wr_info = fsel & (host_req.addr == `E1S_OFS_INFO);
      wire wr_imr_a = fsel & (host_req.addr == `E1S_OFS_IMR_A);
      wire wr_imr_b = fsel & (host_req.addr == `E1S_OFS_IMR_B);

      // receive clock edge taken from stages two and three differing; stage one feeds stage two alone
      wire rclk_edge = rclk_s2_r ^ rclk_s3_r;
      wire clk_lost = (quiet_r == QUIET_LIMIT);
      assign quiet_nxt = rclk_edge ? 7'h00 : (clk_lost ? quiet_r : quiet_r + 7'h01);

      // crc window: evaluate on the thousandth word, counting that word too
      wire crc_last = framer_ev[f].crc_word & (word_cnt_r == `E1S_CRC_WINDOW - 10'd1);
      wire [9:0] err_total = err_cnt_r + {9'h000, framer_ev[f].crc_err};
      wire fas_bad = framer_ev[f].fas_word & framer_ev[f].fas_err;
      wire cas_bad = framer_ev[f].cas_word & framer_ev[f].cas_err;

      // counter clears dominate the timeout; six bits wrap by themselves
      assign sync_cnt_nxt = (!crc_mode_enable[f] || framer_ev[f].crc_sync_ok) ? 6'h00 :
                            (framer_ev[f].crc_mf_timeout ? sync_cnt_r + 6'h01 :
                             sync_cnt_r);

      // receive clock synchroniser and quiet timer
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          rclk_s1_r <= 1'b0;
          rclk_s2_r <= 1'b0;
          rclk_s3_r <= 1'b0;
          quiet_r <= 7'h00;
        end else begin
          rclk_s1_r <= rclk_pin[f];
          rclk_s2_r <= rclk_s1_r;
          rclk_s3_r <= rclk_s2_r;
          quiet_r <= quiet_nxt;
        end
      end

      // crc code word window of 1000, threshold 915
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          word_cnt_r <= 10'h000;
          err_cnt_r <= 10'h000;
          crc_hit_r <= 1'b0;
        end else begin
          crc_hit_r <= crc_last & (err_total >= `E1S_CRC_ERR_LIMIT);
          if (crc_last) begin
            word_cnt_r <= 10'h000;
            err_cnt_r <= 10'h000;
          end else if (framer_ev[f].crc_word) begin
            word_cnt_r <= word_cnt_r + 10'h001;
            err_cnt_r <= err_total;
          end
        end
      end

      // consecutive alignment word error runs; a good word restarts the run
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          fas_run_r <= 2'h0;
          fas_hit_r <= 1'b0;
          cas_run_r <= 2'h0;
          cas_hit_r <= 1'b0;
        end else begin
          fas_hit_r <= fas_bad & (fas_run_r == `E1S_FAS_ERR_RUN - 2'd1);
          cas_hit_r <= cas_bad & (cas_run_r == `E1S_CAS_ERR_RUN - 2'd1);
          if (framer_ev[f].fas_word) begin
            fas_run_r <= (fas_bad && fas_run_r != `E1S_FAS_ERR_RUN - 2'd1) ? fas_run_r + 2'd1 : 2'd0;
          end
          if (framer_ev[f].cas_word) begin
            cas_run_r <= (cas_bad && cas_run_r != `E1S_CAS_ERR_RUN - 2'd1) ? cas_run_r + 2'd1 : 2'd0;
          end
        end
      end

      // sync counter and interrupt masks
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sync_cnt_r <= 6'h00;
          imr_a_r[f] <= `E1S_IMR_RESET;
          imr_b_r[f] <= `E1S_IMR_RESET;
        end else begin
          sync_cnt_r <= sync_cnt_nxt;
          if (wr_imr_a) begin
            imr_a_r[f] <= host_req.wdata;
          end
          if (wr_imr_b) begin
            imr_b_r[f] <= host_req.wdata;
          end
        end
      end

      // live synchronizer view; counter bit 1 is not brought out
      assign sync_view[f] = {sync_cnt_r[5:2], sync_cnt_r[0], framer_ev[f].fas_search,
                             framer_ev[f].cas_search, framer_ev[f].crc_search};

      // summary bits: status a at 2n, status b at 2n+1
      assign summ_nxt[2*f] = |(lat_a[f] & imr_a_r[f]);
      assign summ_nxt[2*f+1] = |(lat_b[f] & imr_b_r[f]);

      event_latch8 u_lat_a (
        .clk(clk),
        .rst_n(rst_n),
        .set_ev(framer_ev[f].status_a),
        .mask_stb(wr_a),
        .mask(host_req.wdata),
        .latched(lat_a[f]),
        .read_val(rd_a[f])
      );

      event_latch8 u_lat_b (
        .clk(clk),
        .rst_n(rst_n),
        .set_ev(framer_ev[f].status_b),
        .mask_stb(wr_b),
        .mask(host_req.wdata),
        .latched(lat_b[f]),
        .read_val(rd_b[f])
      );

      // receive information events, store slips taken straight from the stores
      event_latch8 u_lat_info (
        .clk(clk),
        .rst_n(rst_n),
        .set_ev({framer_ev[f].tx_full, framer_ev[f].tx_empty, clk_lost,
                 framer_ev[f].rx_full, framer_ev[f].rx_empty, crc_hit_r,
                 fas_hit_r, cas_hit_r}),
        .mask_stb(wr_info),
        .mask(host_req.wdata),
        .latched(lat_info[f]),
        .read_val(rd_info[f])
      );

      clock_loss_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_lost |=> lat_info[f][`E1S_INFO_CLK_LOST])
        else $error("receive clock loss not latched");
      // the edge itself restarts the timer at zero, so eight quiet cycles leave seven
      quiet_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rclk_edge ##1 (!rclk_edge) [*8]) |-> (quiet_r == 7'h07))
        else $error("receive clock quiet timer off count");
      sync_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!crc_mode_enable[f] || framer_ev[f].crc_sync_ok) |=> (sync_cnt_r == 6'h00))
        else $error("sync counter not cleared");
      sync_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (crc_mode_enable[f] && !framer_ev[f].crc_sync_ok && framer_ev[f].crc_mf_timeout)
        |=> (sync_cnt_r == 6'($past(sync_cnt_r) + 6'h01)))
        else $error("sync counter did not step by one");
      sync_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (crc_mode_enable[f] && !framer_ev[f].crc_sync_ok && framer_ev[f].crc_mf_timeout &&
         sync_cnt_r == 6'h3f) |=> (sync_cnt_r == 6'h00))
        else $error("sync counter did not wrap");
      fas_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        (fas_bad && fas_run_r == 2'd2) |=> ##1 lat_info[f][`E1S_INFO_FAS_RESYNC])
        else $error("frame alignment resync not reported");
      // resync reports take two steps: the registered hit, then the latch
      sequence cas_hit_s;
        cas_bad && (cas_run_r == 2'd1);
      endsequence
      sequence crc_hit_s;
        crc_last && (err_total >= `E1S_CRC_ERR_LIMIT);
      endsequence
      cas_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        cas_hit_s |=> ##1 lat_info[f][`E1S_INFO_CAS_RESYNC])
        else $error("multiframe resync not reported");
      crc_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
        crc_hit_s |=> ##1 lat_info[f][`E1S_INFO_CRC_RESYNC])
        else $error("crc resync not reported");
      crc_window_a: assert property (@(posedge clk) disable iff (!rst_n)
        crc_last |=> (word_cnt_r == 10'h000))
        else $error("crc window did not restart");
      slip_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
        framer_ev[f].tx_full |=> lat_info[f][`E1S_INFO_TX_FULL])
        else $error("transmit store full not latched");
      slip_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
        framer_ev[f].rx_empty |=> lat_info[f][`E1S_INFO_RX_EMPTY])
        else $error("receive store empty not latched");
      summ_b_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        (summ_r[2*f+1] == |$past(lat_b[f] & imr_b_r[f])))
        else $error("summary bit does not track status b");
      summ_a_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        (summ_r[2*f] == |$past(lat_a[f] & imr_a_r[f])))
        else $error("summary bit does not track status a");
    end
  endgenerate

  // read mux: latched registers return the captured read value, sync view is live
  assign rdata_nxt = (host_req.addr == `E1S_OFS_STATUS_A) ? rd_a[sel_f] :
                     (host_req.addr == `E1S_OFS_STATUS_B) ? rd_b[sel_f] :
                     (host_req.addr == `E1S_OFS_INFO) ? rd_info[sel_f] :
                     (host_req.addr == `E1S_OFS_IMR_A) ? imr_a_r[sel_f] :
                     (host_req.addr == `E1S_OFS_IMR_B) ? imr_b_r[sel_f] :
                     (host_req.addr == `E1S_OFS_SYNC) ? sync_view[sel_f] :
                     (host_req.addr == `E1S_OFS_SUMMARY) ? summ_r : 8'h00;

  // read data and shared interrupt, both registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= `E1S_RDATA_RESET;
      summ_r <= 8'h00;
      int_n_r <= 1'b1;
    end else begin
      if (host_rd) begin
        rdata_r <= rdata_nxt;
      end
      summ_r <= summ_nxt;
      int_n_r <= ~|summ_nxt;
    end
  end

  assign host_rdata = rdata_r;
  assign int_n = int_n_r;

  default clocking mcb @(posedge clk); endclocking
  default disable iff (!rst_n);

  int_tie_a: assert property (int_n_r == !(|summ_r))
    else $error("interrupt pin disagrees with summary");
  sync_live_a: assert property ((host_rd && host_req.addr == `E1S_OFS_SYNC)
    |=> (rdata_r == $past(sync_view[sel_f])))
    else $error("sync register read not live");

  // a pending unmasked alarm pulls the pin one edge later, a quiet summary lets it go
  sequence alarm_pending_s;
    (summ_nxt != 8'h00);
  endsequence
  sequence alarm_quiet_s;
    (summ_nxt == 8'h00);
  endsequence
  int_low_a: assert property (alarm_pending_s |=> !int_n_r)
    else $error("interrupt not driven for a pending alarm");
  int_release_a: assert property (alarm_quiet_s |=> int_n_r)
    else $error("interrupt held with nothing pending");
  idle_rdata_a: assert property (!host_rd |=> $stable(rdata_r))
    else $error("read data moved without a read");

endmodule : e1_status_regs

// >>> e1s_consts.svh
// offsets, field positions, reset values and timing counts of the status block
`ifndef E1S_CONSTS_SVH
`define E1S_CONSTS_SVH

`define E1S_OFS_STATUS_A 8'h06
`define E1S_OFS_STATUS_B 8'h07
`define E1S_OFS_INFO 8'h08
`define E1S_OFS_IMR_A 8'h16
`define E1S_OFS_IMR_B 8'h17
`define E1S_OFS_SYNC 8'h1e
`define E1S_OFS_SUMMARY 8'h1f

`define E1S_IMR_RESET 8'h00
`define E1S_RDATA_RESET 8'h00

`define E1S_INFO_TX_FULL 7
`define E1S_INFO_TX_EMPTY 6
`define E1S_INFO_CLK_LOST 5
`define E1S_INFO_RX_FULL 4
`define E1S_INFO_RX_EMPTY 3
`define E1S_INFO_CRC_RESYNC 2
`define E1S_INFO_FAS_RESYNC 1
`define E1S_INFO_CAS_RESYNC 0

`define E1S_CLK_PERIOD_NS 40
`define E1S_RCLK_QUIET_NS 3000
`define E1S_RCLK_QUIET_CYC ((`E1S_RCLK_QUIET_NS + `E1S_CLK_PERIOD_NS - 1) / `E1S_CLK_PERIOD_NS)

`define E1S_CRC_WINDOW 10'd1000
`define E1S_CRC_ERR_LIMIT 10'd915
`define E1S_FAS_ERR_RUN 2'd3
`define E1S_CAS_ERR_RUN 2'd2

`endif

// >>> e1s_pkg.sv
// types shared by the status block, the host model and the bench
package e1s_pkg;

  // one host port access, all fields sampled on the same edge
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [1:0] fs;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // event and state inputs from one framer's receive/transmit logic
  typedef struct packed {
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
    logic crc_word;
    logic crc_err;
    logic fas_word;
    logic fas_err;
    logic cas_word;
    logic cas_err;
    logic fas_search;
    logic cas_search;
    logic crc_search;
    logic crc_mf_timeout;
    logic crc_sync_ok;
  } framer_ev_t;

endpackage : e1s_pkg

// >>> event_latch8.sv
// eight sticky event bits with mask-write read capture
`timescale 1ns/100ps
module event_latch8 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] set_ev,
  input wire logic mask_stb,
  input wire logic [7:0] mask,
  output logic [7:0] latched,
  output logic [7:0] read_val
);

  logic [7:0] latched_r;
  logic [7:0] latched_nxt;
  logic [7:0] read_r;
  logic [7:0] read_nxt;
  logic [7:0] cur_state;

  // current event state seen by a mask write: sticky bit or event this cycle
  assign cur_state = latched_r | set_ev;
  // masked bits clear, but an event in the same cycle wins
  assign latched_nxt = mask_stb ? ((latched_r & ~mask) | set_ev) : cur_state;
  // only masked bits of the read value move
  assign read_nxt = mask_stb ? ((read_r & ~mask) | (cur_state & mask)) : read_r;

  // state update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latched_r <= 8'h00;
      read_r <= 8'h00;
    end else begin
      latched_r <= latched_nxt;
      read_r <= read_nxt;
    end
  end

  assign latched = latched_r;
  assign read_val = read_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sticky_hold_a: assert property (!mask_stb |=> ((($past(latched_r) & ~latched_r)) == 8'h00))
    else $error("latched bit dropped without a mask write");
  read_load_a: assert property (mask_stb |=>
    ((read_r & $past(mask)) == ($past(cur_state) & $past(mask))))
    else $error("masked bit did not capture current event state");
  read_hold_a: assert property (mask_stb |=>
    ((read_r & ~$past(mask)) == ($past(read_r) & ~$past(mask))))
    else $error("unmasked read bit changed");
  mask_clear_a: assert property (mask_stb |=>
    ((latched_r & $past(mask) & ~$past(set_ev)) == 8'h00))
    else $error("masked bit not cleared");
  set_wins_a: assert property ((set_ev != 8'h00) |=>
    ((latched_r & $past(set_ev)) == $past(set_ev)))
    else $error("event lost against a clear");

endmodule : event_latch8

// >>> host_cpu.sv
// host processor model on the framer register port
`timescale 1ns/100ps
module host_cpu (
  input wire logic clk,
  output e1s_pkg::host_req_t host_req,
  input wire logic [7:0] host_rdata
);
  // bus idles deselected from time zero
  initial begin
    host_req = '0;
  end

  // one access, strobe held over exactly one rising edge, then released
  task automatic acc(input logic w, input logic [1:0] fs, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    host_req = '{cs: 1'b1, wr: w, rd: ~w, fs: fs, addr: a, wdata: d};
    @(negedge clk);
    q = host_rdata;
    // released lines show inverted values so stale data cannot pass
    host_req = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, fs: ~fs, addr: ~a, wdata: ~d};
  endtask : acc

  // mask, read, write back read and mask so late arrivals on bits that read set are cleared too
  task automatic poll(input logic [1:0] fs, input logic [7:0] a, input logic [7:0] m,
                      output logic [7:0] q);
    logic [7:0] dummy;
    acc(1'b1, fs, a, m, dummy);
    acc(1'b0, fs, a, 8'h00, q);
    acc(1'b1, fs, a, q & m, dummy);
  endtask : poll
endmodule : host_cpu

// >>> e1_framer_status_latch_irq_test.sv
// self-checking bench for the framer status and interrupt block
`timescale 1ns/100ps
`include "e1s_consts.svh"
module e1_framer_status_latch_irq_test;
  logic clk;
  logic rst_n;
  e1s_pkg::host_req_t host_req;
  logic [7:0] host_rdata;
  e1s_pkg::framer_ev_t ev [4];
  logic [3:0] rclk_pin;
  logic [3:0] rclk_run;
  logic [3:0] crc_mode_enable;
  logic int_n;
  logic [7:0] q;
  int err_total;
  int check_count;

  e1_status_regs uut (.clk(clk), .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata),
    .framer_ev(ev), .rclk_pin(rclk_pin), .crc_mode_enable(crc_mode_enable), .int_n(int_n));
  host_cpu host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // line clocks near 5 MHz, any framer's may be stopped
  initial begin
    rclk_pin = 4'h0;
    forever #100 rclk_pin = rclk_pin ^ rclk_run;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // one alignment or code word: kind 0 frame, 1 multiframe, 2 crc
  task automatic word(input int f, input int k, input logic e);
    @(negedge clk);
    ev[f].fas_word = (k == 0);
    ev[f].cas_word = (k == 1);
    ev[f].crc_word = (k == 2);
    ev[f].fas_err = e;
    ev[f].cas_err = e;
    ev[f].crc_err = e;
    @(negedge clk);
    ev[f] = '0;
  endtask : word

  task automatic tmo(input int k);
    repeat (k) begin
      @(negedge clk);
      ev[0].crc_mf_timeout = 1'b1;
      @(negedge clk);
      ev[0].crc_mf_timeout = 1'b0;
    end
  endtask : tmo

  task automatic sync_is(input logic [5:0] c, input logic [2:0] s);
    host.acc(1'b0, 2'd0, `E1S_OFS_SYNC, 8'h00, q);
    chk8(q, {c[5:2], c[0], s}, "sync state");
  endtask : sync_is

  task automatic t_reset;
    chk1(int_n, 1'b1, "int idle after reset");
    host.acc(1'b0, 2'd0, `E1S_OFS_SUMMARY, 8'h00, q);
    chk8(q, 8'h00, "summary after reset");
    host.poll(2'd2, `E1S_OFS_INFO, 8'hff, q);
    chk8(q, 8'h00, "info after reset");
  endtask : t_reset

  task automatic t_irq;
    // masks reset to all masked, so a latched alarm stays quiet
    @(negedge clk);
    ev[1].status_a = 8'h01;
    @(negedge clk);
    ev[1].status_a = 8'h00;
    tick(3);
    chk1(int_n, 1'b1, "masked alarm");
    host.poll(2'd1, `E1S_OFS_STATUS_A, 8'h01, q);
    chk8(q, 8'h01, "masked alarm latched");
    for (int f = 0; f < 4; f++) begin
      host.acc(1'b1, f[1:0], `E1S_OFS_IMR_A, 8'h01, q);
      host.acc(1'b1, f[1:0], `E1S_OFS_IMR_B, 8'h01, q);
      @(negedge clk);
      ev[f].status_a = 8'h01;
      ev[f].status_b = 8'h01;
      @(negedge clk);
      ev[f].status_a = 8'h00;
      ev[f].status_b = 8'h00;
      tick(2);
      chk1(int_n, 1'b0, "unmasked alarm");
      host.acc(1'b0, 2'd0, `E1S_OFS_SUMMARY, 8'h00, q);
      chk8(q, 8'h03 << (2 * f), "summary map");
      host.acc(1'b0, f[1:0], `E1S_OFS_IMR_B, 8'h00, q);
      chk8(q, 8'h01, "mask read back");
      host.poll(f[1:0], `E1S_OFS_STATUS_A, 8'h01, q);
      // status a cleared, so only the status b bit of this framer may remain
      host.acc(1'b0, 2'd0, `E1S_OFS_SUMMARY, 8'h00, q);
      chk8(q, 8'h02 << (2 * f), "summary status b alone");
      host.poll(f[1:0], `E1S_OFS_STATUS_B, 8'h01, q);
      chk8(q, 8'h01, "second alarm latched");
      tick(2);
      chk1(int_n, 1'b1, "alarms cleared");
    end
  endtask : t_irq

  task automatic t_slips;
    logic [7:0] mk [3] = '{8'h80, 8'h40, 8'h18};
    logic [7:0] ex [3] = '{8'h80, 8'hc0, 8'hd8};
    @(negedge clk);
    ev[1].tx_full = 1'b1;
    ev[1].tx_empty = 1'b1;
    ev[1].rx_full = 1'b1;
    ev[1].rx_empty = 1'b1;
    @(negedge clk);
    ev[1] = '0;
    tick(3);
    chk1(int_n, 1'b1, "info bits never interrupt");
    foreach (mk[i]) begin
      host.acc(1'b1, 2'd1, `E1S_OFS_INFO, mk[i], q);
      host.acc(1'b0, 2'd1, `E1S_OFS_INFO, 8'h00, q);
      chk8(q, ex[i], "slip bits");
    end
    host.poll(2'd1, `E1S_OFS_INFO, 8'hff, q);
    chk8(q, 8'h00, "slips cleared");
  endtask : t_slips

  task automatic t_align;
    logic [4:0] fp = 5'b11011;
    foreach (fp[i]) word(3, 0, fp[i]);
    host.poll(2'd3, `E1S_OFS_INFO, 8'h03, q);
    chk8(q, 8'h00, "broken error runs");
    word(3, 0, 1'b1);
    word(3, 1, 1'b1);
    word(3, 1, 1'b0);
    word(3, 1, 1'b1);
    tick(3);
    host.poll(2'd3, `E1S_OFS_INFO, 8'h03, q);
    chk8(q, 8'h02, "three frame errors");
    word(3, 1, 1'b1);
    tick(3);
    host.poll(2'd3, `E1S_OFS_INFO, 8'h03, q);
    chk8(q, 8'h01, "two multiframe errors");
  endtask : t_align

  task automatic t_crc;
    for (int n = 914; n <= 915; n++) begin
      for (int i = 0; i < 1000; i++) word(0, 2, i < n);
      tick(3);
      host.poll(2'd0, `E1S_OFS_INFO, 8'h04, q);
      chk8(q, (n == 915) ? 8'h04 : 8'h00, "crc window");
    end
  endtask : t_crc

  task automatic t_clock;
    host.poll(2'd2, `E1S_OFS_INFO, 8'h20, q);
    @(negedge clk);
    rclk_run[2] = 1'b0;
    tick(44);
    host.poll(2'd2, `E1S_OFS_INFO, 8'h20, q);
    chk8(q, 8'h00, "clock quiet below 2us");
    tick(60);
    host.poll(2'd2, `E1S_OFS_INFO, 8'h20, q);
    chk8(q, 8'h20, "clock quiet past 4us");
    rclk_run[2] = 1'b1;
    tick(10);
    host.poll(2'd2, `E1S_OFS_INFO, 8'h20, q);
    chk8(q, 8'h20, "set again while quiet");
    host.poll(2'd2, `E1S_OFS_INFO, 8'h20, q);
    chk8(q, 8'h00, "clock back");
  endtask : t_clock

  task automatic t_ssr;
    @(negedge clk);
    ev[0].fas_search = 1'b1;
    ev[0].crc_search = 1'b1;
    tmo(5);
    sync_is(6'd5, 3'b101);
    // fifty timeouts mark the 400 ms point where the host gives up the crc4 search
    tmo(45);
    sync_is(6'd50, 3'b101);
    tmo(13);
    sync_is(6'd63, 3'b101);
    tmo(1);
    sync_is(6'd0, 3'b101);
    ev[0].fas_search = 1'b0;
    ev[0].crc_search = 1'b0;
    ev[0].cas_search = 1'b1;
    tmo(6);
    sync_is(6'd6, 3'b010);
    ev[0].crc_sync_ok = 1'b1;
    tick(1);
    ev[0].crc_sync_ok = 1'b0;
    sync_is(6'd0, 3'b010);
    tmo(3);
    crc_mode_enable[0] = 1'b0;
    tmo(2);
    sync_is(6'd0, 3'b010);
    crc_mode_enable[0] = 1'b1;
    ev[0] = '0;
  endtask : t_ssr

  initial begin
    err_total = 0;
    check_count = 0;
    rst_n = 1'b0;
    rclk_run = 4'hf;
    crc_mode_enable = 4'hf;
    foreach (ev[i]) ev[i] = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_irq();
    t_slips();
    t_align();
    t_crc();
    t_clock();
    t_ssr();
    report_and_stop();
  end

  // about 5000 cycles expected, generous margin
  initial begin
    #800000;
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : e1_framer_status_latch_irq_test
